/* File: hdl/adsq_ctrl.sv */
// Summary of operation
// - result, control, clock registers at 24h-27h
// - result bytes ignore software writes
// - start runs after start bit falls
// - start rise resets converter, sets pending
// - completion clears pending, sets irq request
// - pending flag is control bit six
// - control bits 1:0 pick analog input
// - control bits 5:3 set analog line count
// - analog lines lose digital and pull-high
// - all-zero port config powers converter off
// - pending flag undefined without reinit pulse
// - clock bits 1:0 pick divide 2/8/32
// - result lsb in low bit7, rest high
`include "adsq_map.svh"
module adsq_ctrl #(
    parameter int RES_W = 9
) (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic clk_en_i,
    input wire adsq_pkg::adsq_bus_s bus_i,
    output logic [7:0] rdata_o,
    input wire logic comp_bit_i,
    input wire logic irq_enable_i,
    input wire logic irq_clear_i,
    output logic conv_irq_request_o,
    output logic conv_irq_o,
    output adsq_pkg::adsq_analog_s analog_o
);
    import adsq_pkg::*;

    logic [7:0] ctl_q, ctl_d;
    logic [7:0] clk_q, clk_d;
    logic [RES_W-1:0] res_q, res_d;
    logic [RES_W-1:0] sar_q, sar_d;
    logic [3:0] step_q, step_d;
    logic [7:0] div_q, div_d;
    logic tick_q, tick_d;
    adsq_state_e st_q, st_d;
    logic irq_req_q, irq_req_d;
    logic irq_q, irq_d;
    logic [7:0] rdata_q, rdata_d;
    adsq_analog_s ana_q, ana_d;
    logic start_wr, start_rise, start_fall, done;

    function automatic logic [3:0] lines_from_cfg(input logic [2:0] cfg);
        case (cfg)
            3'b000: lines_from_cfg = 4'h0;
            3'b001: lines_from_cfg = 4'h1;
            3'b010: lines_from_cfg = 4'h3;
            3'b011: lines_from_cfg = 4'h7;
            default: lines_from_cfg = 4'hf;
        endcase
    endfunction : lines_from_cfg

    function automatic logic [7:0] div_from_sel(input logic [1:0] sel);
        case (sel)
            2'b00: div_from_sel = `ADSQ_DIV_2;
            2'b01: div_from_sel = `ADSQ_DIV_8;
            2'b10: div_from_sel = `ADSQ_DIV_32;
            // undefined code: keep slowest clock rather than stall
            default: div_from_sel = `ADSQ_DIV_32;
        endcase
    endfunction : div_from_sel

    assign start_wr = bus_i.wr && bus_i.addr == `ADSQ_ADDR_CONTROL;
    assign start_rise = start_wr && !ctl_q[`ADSQ_CTL_START_BIT]
        && bus_i.wdata[`ADSQ_CTL_START_BIT];
    assign start_fall = start_wr && ctl_q[`ADSQ_CTL_START_BIT]
        && !bus_i.wdata[`ADSQ_CTL_START_BIT];

    // converter clock divider
    always_comb begin
        div_d = div_q;
        tick_d = 1'b0;
        // >= rather than == so a smaller divide takes effect at once
        if (div_q >= div_from_sel(clk_q[1:0]) - 8'h01) begin
            div_d = 8'h00;
            tick_d = 1'b1;
        end else begin
            div_d = div_q + 8'h01;
        end
    end

    // conversion sequencer
    always_comb begin
        st_d = st_q;
        sar_d = sar_q;
        step_d = step_q;
        done = 1'b0;
        // a new rise wins over any state: it aborts a run and rearms
        if (start_rise) begin
            st_d = ADSQ_ARMED;
            sar_d = '0;
            step_d = 4'h0;
        end else begin
            case (st_q)
                ADSQ_IDLE: st_d = ADSQ_IDLE;
                ADSQ_ARMED: begin
                    if (start_fall) begin
                        st_d = ADSQ_SAMPLE;
                        step_d = 4'h0;
                    end
                end
                ADSQ_SAMPLE: begin
                    if (tick_q) begin
                        if (step_q == `ADSQ_SAMPLE_STEPS - 4'h1) begin
                            st_d = ADSQ_CONVERT;
                            step_d = 4'h0;
                        end else begin
                            step_d = step_q + 4'h1;
                        end
                    end
                end
                ADSQ_CONVERT: begin
                    if (tick_q) begin
                        // msb first: one decision per converter clock
                        sar_d = {sar_q[RES_W-2:0], comp_bit_i};
                        if (step_q == `ADSQ_CONV_STEPS - 4'h1) begin
                            st_d = ADSQ_IDLE;
                            done = 1'b1;
                        end else begin
                            step_d = step_q + 4'h1;
                        end
                    end
                end
                default: st_d = ADSQ_IDLE;
            endcase
        end
    end

    // registers and flags
    always_comb begin
        ctl_d = ctl_q;
        clk_d = clk_q;
        res_d = res_q;
        irq_req_d = irq_req_q;
        irq_d = 1'b0;
        if (bus_i.wr) begin
            case (bus_i.addr)
                // pending ignores writes; a config change without a start pulse leaves it stale
                `ADSQ_ADDR_CONTROL: ctl_d = {bus_i.wdata[7], ctl_q[6], bus_i.wdata[5:0]};
                `ADSQ_ADDR_CLOCK: clk_d = bus_i.wdata & `ADSQ_CLK_IMPL_MASK;
                default: ;
            endcase
        end
        if (start_rise) begin
            ctl_d[`ADSQ_CTL_PENDING_BIT] = 1'b1;
        end
        if (irq_clear_i) begin
            irq_req_d = 1'b0;
        end
        if (done) begin
            res_d = {sar_q[RES_W-2:0], comp_bit_i};
            ctl_d[`ADSQ_CTL_PENDING_BIT] = 1'b0;
            irq_req_d = 1'b1;
            irq_d = irq_enable_i;
        end
    end

    // read mux and analog controls
    always_comb begin
        rdata_d = 8'h00;
        if (bus_i.rd) begin
            case (bus_i.addr)
                `ADSQ_ADDR_RES_LOW: rdata_d = {res_q[0], 7'h00};
                `ADSQ_ADDR_RES_HIGH: rdata_d = res_q[RES_W-1:1];
                `ADSQ_ADDR_CONTROL: rdata_d = ctl_q;
                `ADSQ_ADDR_CLOCK: rdata_d = clk_q;
                default: rdata_d = 8'h00;
            endcase
        end
        // analog controls are registered so the pads see no decode glitches
        ana_d.analog_en = lines_from_cfg(ctl_q[5:3]);
        ana_d.input_sel = ctl_q[1:0];
        ana_d.power_on = |ctl_q[5:3];
        ana_d.sample = st_q == ADSQ_SAMPLE;
        ana_d.clk_tick = tick_q;
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            ctl_q <= `ADSQ_CTL_RESET;
            clk_q <= `ADSQ_CLK_RESET;
            res_q <= '0;
            sar_q <= '0;
            step_q <= 4'h0;
            div_q <= 8'h00;
            tick_q <= 1'b0;
            st_q <= ADSQ_IDLE;
            irq_req_q <= 1'b0;
            irq_q <= 1'b0;
            rdata_q <= 8'h00;
            ana_q <= '0;
        end else if (clk_en_i) begin
            ctl_q <= ctl_d;
            clk_q <= clk_d;
            res_q <= res_d;
            sar_q <= sar_d;
            step_q <= step_d;
            div_q <= div_d;
            tick_q <= tick_d;
            st_q <= st_d;
            irq_req_q <= irq_req_d;
            irq_q <= irq_d;
            rdata_q <= rdata_d;
            ana_q <= ana_d;
        end
    end

    assign rdata_o = rdata_q;
    assign conv_irq_request_o = irq_req_q;
    assign conv_irq_o = irq_q;
    assign analog_o = ana_q;

    // a start fall only counts from the armed state and not under a new rise
    sequence s_fall_taken;
        clk_en_i && st_q == ADSQ_ARMED && start_fall && !start_rise;
    endsequence

    sequence s_done_taken;
        clk_en_i && done;
    endsequence

    // the request is sticky; the pulse copies the enable seen at completion
    sequence s_done_shown;
        conv_irq_request_o && conv_irq_o == $past(irq_enable_i);
    endsequence

    a_rise_sets_pending: assert property (@(posedge clock_i) disable iff (rst_i)
        clk_en_i && start_rise |=> ctl_q[`ADSQ_CTL_PENDING_BIT] && st_q == ADSQ_ARMED)
        else $error("start rise did not set pending");
    a_fall_starts_run: assert property (@(posedge clock_i) disable iff (rst_i)
        clk_en_i && st_q == ADSQ_ARMED && start_fall && !start_rise |=> st_q == ADSQ_SAMPLE)
        else $error("start fall did not begin conversion");
    a_done_flags: assert property (@(posedge clock_i) disable iff (rst_i)
        clk_en_i && done && !start_rise |=> !ctl_q[`ADSQ_CTL_PENDING_BIT] && irq_req_q)
        else $error("completion flags wrong");
    a_irq_gated: assert property (@(posedge clock_i) disable iff (rst_i)
        conv_irq_o |-> $past(irq_enable_i))
        else $error("interrupt raised while disabled");
    a_req_sticky: assert property (@(posedge clock_i) disable iff (rst_i)
        clk_en_i && irq_req_q && !irq_clear_i |=> irq_req_q)
        else $error("irq request dropped without clear");
    a_result_ro: assert property (@(posedge clock_i) disable iff (rst_i)
        clk_en_i && !done |=> $stable(res_q))
        else $error("result changed without completion");
    a_power_off: assert property (@(posedge clock_i) disable iff (rst_i)
        ctl_q[5:3] == 3'b000 |=> !analog_o.power_on || $past(!clk_en_i))
        else $error("converter powered with zero config");
    a_clk_zero_bits: assert property (@(posedge clock_i) disable iff (rst_i)
        clk_q[6:2] == 5'h00)
        else $error("clock register unused bits set");
    a_no_early_run: assert property (@(posedge clock_i) disable iff (rst_i)
        st_q == ADSQ_ARMED && clk_en_i && !start_fall |=> st_q != ADSQ_SAMPLE)
        else $error("conversion began without start fall");

    // sample strobe is registered, so it shows one enabled cycle after the state
    a_run_samples: assert property (@(posedge clock_i) disable iff (rst_i)
        s_fall_taken ##1 clk_en_i |=> analog_o.sample)
        else $error("sample strobe missing after start fall");
    a_done_reports: assert property (@(posedge clock_i) disable iff (rst_i)
        s_done_taken |=> s_done_shown)
        else $error("completion not reported on outputs");
    a_rise_resets_sar: assert property (@(posedge clock_i) disable iff (rst_i)
        clk_en_i && start_rise |=> sar_q == '0 && step_q == 4'h0)
        else $error("start rise did not reset converter");
    a_low_byte_pad: assert property (@(posedge clock_i) disable iff (rst_i)
        clk_en_i && bus_i.rd && bus_i.addr == `ADSQ_ADDR_RES_LOW |=> rdata_o[6:0] == 7'h00)
        else $error("unused low result bits not zero");
    a_unmapped_zero: assert property (@(posedge clock_i) disable iff (rst_i)
        clk_en_i && !(bus_i.rd && bus_i.addr >= `ADSQ_ADDR_RES_LOW
        && bus_i.addr <= `ADSQ_ADDR_CLOCK) |=> rdata_o == 8'h00)
        else $error("read data not zero outside the register block");
    a_tick_single: assert property (@(posedge clock_i) disable iff (rst_i)
        clk_en_i && tick_q |=> !tick_q)
        else $error("converter clock tick held two cycles");
    a_pending_in_run: assert property (@(posedge clock_i) disable iff (rst_i)
        st_q != ADSQ_IDLE |-> ctl_q[`ADSQ_CTL_PENDING_BIT])
        else $error("pending flag low while a conversion is open");
    a_idle_quiet: assert property (@(posedge clock_i) disable iff (rst_i)
        clk_en_i && st_q == ADSQ_IDLE && !start_rise |=> st_q == ADSQ_IDLE)
        else $error("sequencer left idle without a start rise");
    a_all_lines: assert property (@(posedge clock_i) disable iff (rst_i)
        clk_en_i && ctl_q[5] |=> analog_o.analog_en == 4'hf)
        else $error("top config bit did not make all lines analog");
    a_power_lines: assert property (@(posedge clock_i) disable iff (rst_i)
        analog_o.analog_en != 4'h0 |-> analog_o.power_on)
        else $error("analog lines set with converter powered off");
    a_sample_only: assert property (@(posedge clock_i) disable iff (rst_i)
        clk_en_i && st_q != ADSQ_SAMPLE |=> !analog_o.sample)
        else $error("sample strobe outside the sample phase");

    // clock enable low must leave every piece of state where it was
    a_freeze_state: assert property (@(posedge clock_i) disable iff (rst_i)
        !clk_en_i |=> $stable(ctl_q) && $stable(st_q) && $stable(res_q))
        else $error("state moved while clock enable low");
endmodule : adsq_ctrl

/* File: hdl/adsq_map.svh */
`ifndef ADSQ_MAP_SVH
`define ADSQ_MAP_SVH
`define ADSQ_ADDR_RES_LOW 8'h24
`define ADSQ_ADDR_RES_HIGH 8'h25
`define ADSQ_ADDR_CONTROL 8'h26
`define ADSQ_ADDR_CLOCK 8'h27
`define ADSQ_CTL_START_BIT 7
`define ADSQ_CTL_PENDING_BIT 6
`define ADSQ_CTL_CFG_HI 5
`define ADSQ_CTL_CFG_LO 3
`define ADSQ_CTL_SEL_HI 2
`define ADSQ_CTL_SEL_LO 0
`define ADSQ_CTL_RESET 8'h40
`define ADSQ_CLK_RESET 8'h00
`define ADSQ_CLK_IMPL_MASK 8'h83
`define ADSQ_DIV_2 8'h02
`define ADSQ_DIV_8 8'h08
`define ADSQ_DIV_32 8'h20
`define ADSQ_CONV_STEPS 4'h9
`define ADSQ_SAMPLE_STEPS 4'h2
`endif

/* File: hdl/adsq_pkg.sv */
package adsq_pkg;
    typedef enum logic [1:0] {
        ADSQ_IDLE = 2'b00,
        ADSQ_ARMED = 2'b01,
        ADSQ_SAMPLE = 2'b10,
        ADSQ_CONVERT = 2'b11
    } adsq_state_e;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } adsq_bus_s;

    typedef struct packed {
        logic [3:0] analog_en;
        logic [1:0] input_sel;
        logic power_on;
        logic sample;
        logic clk_tick;
    } adsq_analog_s;
endpackage : adsq_pkg

/* File: test/adsq_ctrl_tb.sv */
`include "adsq_map.svh"
`define CHK(got, exp) begin \
    comparisons++; \
    if ((got) !== (exp)) begin \
        err_total++; \
        $display("mismatch at %0t: got %h expected %h", $time, got, exp); \
    end \
end

module adsq_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import adsq_pkg::*;
    logic clock_i = 1'b0;
    logic rst_i = 1'b1;
    logic clk_en_i = 1'b1;
    logic comp_bit_i = 1'b0;
    logic irq_enable_i = 1'b0;
    logic irq_clear_i = 1'b0;
    adsq_bus_s bus_i = '0;
    logic [7:0] rdata_o;
    logic conv_irq_request_o;
    logic conv_irq_o;
    adsq_analog_s analog_o;
    int err_total = 0;
    int comparisons = 0;
    int cycles = 0;
    logic [7:0] d;
    logic irq_seen;

    adsq_ctrl DUT (.clock_i(clock_i), .rst_i(rst_i), .clk_en_i(clk_en_i), .bus_i(bus_i),
        .rdata_o(rdata_o), .comp_bit_i(comp_bit_i), .irq_enable_i(irq_enable_i),
        .irq_clear_i(irq_clear_i), .conv_irq_request_o(conv_irq_request_o),
        .conv_irq_o(conv_irq_o), .analog_o(analog_o));

    always #20 clock_i = ~clock_i;

    // ceiling well above the slowest conversion sequence
    always @(posedge clock_i) begin
        cycles++;
        if (cycles == 20000) begin
            err_total++;
            give_verdict();
        end
    end

    task give_verdict();
        $display("comparisons %0d, mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : give_verdict

    task step();
        @(posedge clock_i);
        #1;
    endtask : step

    // an idle cycle after each access keeps strobes from toggling twice in one step
    task bus_wr(input logic [7:0] a, input logic [7:0] v);
        bus_i.wr = 1'b1;
        bus_i.addr = a;
        bus_i.wdata = v;
        step();
        bus_i.wr = 1'b0;
        step();
    endtask : bus_wr

    task bus_rd(input logic [7:0] a, output logic [7:0] v);
        bus_i.rd = 1'b1;
        bus_i.addr = a;
        step();
        bus_i.rd = 1'b0;
        v = rdata_o;
        step();
    endtask : bus_rd

    task clear_irq();
        irq_clear_i = 1'b1;
        step();
        irq_clear_i = 1'b0;
        step();
    endtask : clear_irq

    task convert(input logic [1:0] sel, input logic cb, input logic en);
        int n;
        int dv;
        dv = (sel == 2'b00) ? 2 : (sel == 2'b01) ? 8 : 32;
        comp_bit_i = cb;
        irq_enable_i = en;
        irq_seen = 1'b0;
        n = 0;
        clear_irq();
        bus_wr(`ADSQ_ADDR_CLOCK, {6'h00, sel});
        // start low first so that the next write is a true rise
        bus_wr(`ADSQ_ADDR_CONTROL, 8'h21);
        bus_wr(`ADSQ_ADDR_CONTROL, 8'ha1);
        bus_rd(`ADSQ_ADDR_CONTROL, d);
        `CHK(d[6], 1'b1)
        bus_wr(`ADSQ_ADDR_CONTROL, 8'h21);
        while (conv_irq_request_o !== 1'b1 && n < 2000) begin
            if (conv_irq_o === 1'b1)
                irq_seen = 1'b1;
            step();
            n++;
        end
        if (conv_irq_o === 1'b1)
            irq_seen = 1'b1;
        `CHK((n >= 10 * dv - 6 && n <= 11 * dv + 4), 1'b1)
        `CHK(irq_seen, en)
        step();
        `CHK(conv_irq_o, 1'b0)
        bus_rd(`ADSQ_ADDR_CONTROL, d);
        `CHK(d[6], 1'b0)
        bus_rd(`ADSQ_ADDR_RES_HIGH, d);
        `CHK(d, {8{cb}})
        bus_wr(`ADSQ_ADDR_RES_HIGH, {8{~cb}});
        bus_wr(`ADSQ_ADDR_RES_LOW, {8{~cb}});
        bus_rd(`ADSQ_ADDR_RES_LOW, d);
        `CHK(d, {cb, 7'h00})
        bus_rd(`ADSQ_ADDR_RES_HIGH, d);
        `CHK(d, {8{cb}})
        $display("conversion test sel %0d done", sel);
    endtask : convert

    initial begin
        repeat (12) @(posedge clock_i);
        #1;
        rst_i = 1'b0;
        step();
        bus_rd(`ADSQ_ADDR_CONTROL, d);
        `CHK(d, 8'h40)
        bus_rd(`ADSQ_ADDR_CLOCK, d);
        `CHK(d, 8'h00)
        `CHK(analog_o.power_on, 1'b0)
        bus_wr(`ADSQ_ADDR_CLOCK, 8'h7f);
        bus_rd(`ADSQ_ADDR_CLOCK, d);
        `CHK(d, 8'h03)
        bus_rd(8'h28, d);
        `CHK(d, 8'h00)
        $display("register test done");
        for (int c = 0; c < 8; c++) begin
            // every config change is written together with its start rise; start is cleared a few cycles later
            bus_wr(`ADSQ_ADDR_CONTROL, {2'b10, c[2:0], 1'b0, c[1:0]});
            `CHK(analog_o.analog_en, c[2] ? 4'hf : 4'((1 << c) - 1))
            `CHK(analog_o.power_on, (c != 0))
            `CHK(analog_o.input_sel, c[1:0])
            bus_rd(`ADSQ_ADDR_CONTROL, d);
            `CHK(d, {2'b11, c[2:0], 1'b0, c[1:0]})
            bus_wr(`ADSQ_ADDR_CONTROL, {2'b00, c[2:0], 1'b0, c[1:0]});
        end
        $display("configuration test done");
        bus_wr(`ADSQ_ADDR_CLOCK, 8'h00);
        bus_wr(`ADSQ_ADDR_CONTROL, 8'ha0);
        repeat (60) step();
        `CHK(conv_irq_request_o, 1'b0)
        bus_rd(`ADSQ_ADDR_CONTROL, d);
        `CHK(d[6], 1'b1)
        $display("held start test done");
        clk_en_i = 1'b0;
        bus_wr(`ADSQ_ADDR_CONTROL, 8'h20);
        clk_en_i = 1'b1;
        bus_rd(`ADSQ_ADDR_CONTROL, d);
        `CHK(d, 8'he0)
        $display("clock enable test done");
        for (int s = 0; s < 4; s++)
            convert(s[1:0], s[0], ~s[0]);
        bus_wr(`ADSQ_ADDR_CONTROL, 8'ha0);
        `CHK(conv_irq_request_o, 1'b1)
        clear_irq();
        `CHK(conv_irq_request_o, 1'b0)
        $display("request hold test done");
        give_verdict();
    end
endmodule : adsq_ctrl_tb
